// >>> design/sfp_pkg.sv
// shared constants, types and opcodes of the serial flash command port
//
// Contract
// - sample serial input on rising clock edges
// - change serial output on falling clock edges
// - active only while chip select low
// - write-protect low enforces status write lock
// - hold low suspends shifting, keeps transaction
// - bytes shift most significant bit first
// - output high impedance while receiving bits
// - drive output only for returned data
// - clock level at select picks mode 0/3
// - reads: 03h plus address, 0Bh adds dummy
// - D7h/20h small erase, D8h sector erase
// - page program: 02h, address, data bytes
// - listed single-byte opcodes are complete commands
// - status write: 01h plus one data byte
// - upper address bits 23..18 are ignored
// - 256-byte pages, 4K and 64K erase units
// - erase times 150ms, 250ms, 1.6s maximum
// - page program busy 4.0ms typical, 5.0ms max
// - read address increments and wraps to zero
// - status read repeats bits 7..0 continuously
package sfp_pkg;

  // opcodes
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_SSE   = 8'hD7;
  localparam logic [7:0] OP_SSE2  = 8'h20;
  localparam logic [7:0] OP_SE    = 8'hD8;
  localparam logic [7:0] OP_CE    = 8'hC7;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_DPD   = 8'hB9;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_RDID  = 8'h9F;
  localparam logic [7:0] OP_RES   = 8'hAB;

  // status field positions and power-on values of the kept bits
  localparam int SR_RDY  = 0;
  localparam int SR_WEN  = 1;
  localparam int SR_BP0  = 2;
  localparam int SR_BP1  = 3;
  localparam int SR_LOCK = 7;
  localparam logic       LOCK_RST = 1'b0;
  localparam logic [1:0] BP_RST   = 2'h0;

  // geometry: address, page, small sector and sector widths
  localparam int ADDR_W = 18;
  localparam int PAGE_W = 8;
  localparam int SSEC_W = 12;
  localparam int SEC_W  = 16;

  // bit and byte counting
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [7:0] ERASED    = 8'hFF;

  // timing, as printed, and cycle counts at the core clock
  localparam int CLK_MHZ     = 40;
  localparam int T_SSE_US    = 150000;
  localparam int T_SE_US     = 250000;
  localparam int T_CE_US     = 1600000;
  localparam int T_PP_US     = 4000;
  localparam int T_PP_MAX_US = 5000;
  localparam int N_SSE_DEF   = T_SSE_US * CLK_MHZ;
  localparam int N_SE_DEF    = T_SE_US * CLK_MHZ;
  localparam int N_CE_DEF    = T_CE_US * CLK_MHZ;
  localparam int N_PP_DEF    = T_PP_US * CLK_MHZ;

  // transaction phases
  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_ADDR, S_DUMMY, S_DIN, S_OUT, S_DONE, S_IGN
  } sfp_state_t;

  // what the output phase returns
  typedef enum logic [1:0] {SRC_ARRAY, SRC_STATUS, SRC_ID1, SRC_ID2} sfp_src_t;

  // host-driven pins
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic hold_n;
  } sfp_pins_t;

  // serial output pin as level plus enable
  typedef struct packed {
    logic so;
    logic so_oe;
  } sfp_so_t;

endpackage

// >>> design/sfp_sync.sv
// two-flop pin synchroniser with edge detection behind the second flop
`timescale 1ns/1ps
`default_nettype none
module sfp_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // asynchronous pins
  input  wire logic [W-1:0] d,
  // synchronised level and edges
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] m_q;
  logic [W-1:0] s_q;
  logic [W-1:0] p_q;

  // first flop feeds only the second; edges compare second and third
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      m_q <= '1;
      s_q <= '1;
      p_q <= '1;
    end else begin
      m_q <= d;
      s_q <= m_q;
      p_q <= s_q;
    end
  end

  assign q    = s_q;
  assign rise = s_q & ~p_q;
  assign fall = ~s_q & p_q;
endmodule
`default_nettype wire

// >>> design/sfp_port.sv
// serial flash command port: pin sampling, command decode, array and busy timing
`timescale 1ns/1ps
`default_nettype none
module sfp_port #(
  parameter int         AW     = sfp_pkg::ADDR_W,
  parameter int         N_SSE  = sfp_pkg::N_SSE_DEF,
  parameter int         N_SE   = sfp_pkg::N_SE_DEF,
  parameter int         N_CE   = sfp_pkg::N_CE_DEF,
  parameter int         N_PP   = sfp_pkg::N_PP_DEF,
  parameter logic [7:0] ID1_B0 = 8'h5A, // arbitrary value
  parameter logic [7:0] ID1_B1 = 8'hA5, // arbitrary value
  parameter logic [7:0] ID2_B  = 8'h3C  // arbitrary value
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // host pins
  input  wire sfp_pkg::sfp_pins_t pins,
  // serial output
  output var  sfp_pkg::sfp_so_t   so_pin
);
  import sfp_pkg::*;

  sfp_pins_t  lv, rs, fl;
  sfp_state_t st_q, st_d;
  sfp_src_t   src_q, src_d;
  logic [7:0]    op_q, op_d, sh_q, ob_q, rdata_q;
  logic [2:0]    bit_q, obit_q;
  logic [1:0]    nb_q, nb_d, bp_q;
  logic [AW-1:0] addr_q, addr_d, er_addr_q, er_end_q;
  logic [31:0]   cnt_q;
  logic          cmd_ok_q, cmd_ok_d, so_q, oe_q, mode3_q, seen_q, idx_q;
  logic          wen_q, lock_q, pd_q, er_q;
  logic [7:0]    mem [0:(1<<AW)-1];

  // pins cross into the core clock before anything looks at them
  sfp_sync #(.W($bits(sfp_pins_t))) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    (pins),
    .q    (lv),
    .rise (rs),
    .fall (fl)
  );

  // qualified edges; hold freezes both shift directions
  wire logic       sel      = ~lv.cs_n;
  wire logic       cs_fall  = fl.cs_n;
  wire logic       cs_rise  = rs.cs_n;
  wire logic       rise_ok  = sel & lv.hold_n & rs.sck & ~cs_fall;
  wire logic       fall_ok  = sel & lv.hold_n & fl.sck & (seen_q | ~mode3_q);
  wire logic [7:0] byte_in  = {sh_q[6:0], lv.si};
  wire logic       byte_done = rise_ok & (bit_q == BIT_LAST);
  wire logic       busy     = (cnt_q != 32'h0000_0000) | er_q;
  wire logic       locked   = lock_q & ~lv.wp_n;

  // status byte as seen by the host
  wire logic [7:0] sr = {lock_q, 3'h0, bp_q, wen_q, busy};

  // opcode classes
  wire logic is_erase = (op_q == OP_SSE) | (op_q == OP_SSE2) | (op_q == OP_SE);
  wire logic wr_class = (byte_in == OP_SSE) | (byte_in == OP_SSE2) | (byte_in == OP_SE)
                      | (byte_in == OP_CE) | (byte_in == OP_PP) | (byte_in == OP_WRSR);
  wire logic exec     = cs_rise & cmd_ok_q;

  // commands acted on at deselection
  wire logic do_wren  = exec & (st_q == S_DONE) & (op_q == OP_WREN);
  wire logic do_wrdi  = exec & (st_q == S_DONE) & (op_q == OP_WRDI);
  wire logic do_dpd   = exec & (st_q == S_DONE) & (op_q == OP_DPD);
  wire logic do_res   = exec & (st_q == S_ADDR) & (op_q == OP_RES);
  wire logic do_er    = exec & wen_q & (st_q == S_DONE) & (is_erase | (op_q == OP_CE));
  wire logic do_pp    = exec & wen_q & (st_q == S_DIN) & (op_q == OP_PP);
  wire logic do_wrsr  = exec & wen_q & ~locked & (st_q == S_DIN) & (op_q == OP_WRSR);

  // erase unit: 4K small sector, 64K sector or whole array
  wire logic [AW-1:0] er_mask = (op_q == OP_CE) ? '1 :
                                (op_q == OP_SE) ? AW'((1 << SEC_W) - 1) :
                                AW'((1 << SSEC_W) - 1);
  wire logic [AW-1:0] er_base = addr_q & ~er_mask;

  // program data merges into the array byte, as flash only clears bits
  wire logic          pp_we = (st_q == S_DIN) & (op_q == OP_PP) & byte_done & wen_q;
  wire logic          mem_we = pp_we | er_q;
  wire logic [AW-1:0] waddr  = er_q ? er_addr_q : addr_q;
  wire logic [7:0]    wdata  = er_q ? ERASED : (rdata_q & byte_in);

  // next byte to shift out
  wire logic [7:0] next_b = (src_q == SRC_STATUS) ? sr :
                            (src_q == SRC_ID1) ? (idx_q ? ID1_B1 : ID1_B0) :
                            (src_q == SRC_ID2) ? ID2_B : rdata_q;
  wire logic out_fall = fall_ok & (st_q == S_OUT);

  // phase sequencing
  always_comb begin
    st_d     = st_q;
    op_d     = op_q;
    nb_d     = nb_q;
    src_d    = src_q;
    addr_d   = addr_q;
    cmd_ok_d = cmd_ok_q;
    case (st_q)
      S_IDLE: begin
      end
      S_CMD: begin
        if (byte_done) begin
          op_d = byte_in;
          nb_d = 2'h0;
          if ((pd_q && byte_in != OP_RES) || (busy && wr_class)) begin
            st_d = S_IGN;
          end else begin
            case (byte_in)
              OP_READ, OP_FREAD, OP_SSE, OP_SSE2, OP_SE, OP_PP: st_d = S_ADDR;
              OP_RES: begin
                st_d     = S_ADDR;
                cmd_ok_d = 1'b1;
              end
              OP_WRSR: st_d = S_DIN;
              OP_RDSR: begin
                st_d  = S_OUT;
                src_d = SRC_STATUS;
              end
              OP_RDID: begin
                st_d  = S_OUT;
                src_d = SRC_ID1;
              end
              OP_CE, OP_WREN, OP_WRDI, OP_DPD: begin
                st_d     = S_DONE;
                cmd_ok_d = 1'b1;
              end
              default: st_d = S_IGN;
            endcase
          end
        end
      end
      S_ADDR: begin
        // any bit after a bare ABh turns it from exit into id read
        if (rise_ok) begin
          cmd_ok_d = 1'b0;
        end
        if (byte_done) begin
          addr_d = AW'({addr_q, byte_in});
          nb_d   = nb_q + 2'h1;
          if (nb_q == ADDR_LAST) begin
            case (op_q)
              OP_READ: begin
                st_d  = S_OUT;
                src_d = SRC_ARRAY;
              end
              OP_FREAD: st_d = S_DUMMY;
              OP_RES: begin
                st_d  = S_OUT;
                src_d = SRC_ID2;
              end
              OP_PP: st_d = S_DIN;
              default: begin
                st_d     = S_DONE;
                cmd_ok_d = 1'b1;
              end
            endcase
          end
        end
      end
      S_DUMMY: begin
        if (byte_done) begin
          st_d  = S_OUT;
          src_d = SRC_ARRAY;
        end
      end
      S_DIN: begin
        if (byte_done) begin
          cmd_ok_d = 1'b1;
          if (op_q == OP_PP) begin
            addr_d = {addr_q[AW-1:PAGE_W], addr_q[PAGE_W-1:0] + 1'b1};
          end else if (cmd_ok_q) begin
            st_d     = S_IGN;
            cmd_ok_d = 1'b0;
          end
        end
      end
      S_DONE: begin
        if (rise_ok) begin
          st_d     = S_IGN;
          cmd_ok_d = 1'b0;
        end
      end
      S_OUT: begin
        if (out_fall && obit_q == BIT_LAST && src_q == SRC_ARRAY) begin
          addr_d = addr_q + 1'b1;
        end
      end
      default: st_d = S_IGN;
    endcase
    if (cs_rise) begin
      st_d     = S_IDLE;
      cmd_ok_d = 1'b0;
    end else if (cs_fall) begin
      st_d     = S_CMD;
      cmd_ok_d = 1'b0;
    end
  end

  // phase registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q     <= S_IDLE;
      op_q     <= 8'h00;
      nb_q     <= 2'h0;
      src_q    <= SRC_ARRAY;
      addr_q   <= '0;
      cmd_ok_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      op_q     <= op_d;
      nb_q     <= nb_d;
      src_q    <= src_d;
      addr_q   <= addr_d;
      cmd_ok_q <= cmd_ok_d;
    end
  end

  // input shifter; mode is caught from the clock level at selection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sh_q    <= 8'h00;
      bit_q   <= 3'h0;
      mode3_q <= 1'b0;
      seen_q  <= 1'b0;
    end else if (cs_fall) begin
      bit_q   <= 3'h0;
      mode3_q <= lv.sck;
      seen_q  <= 1'b0;
    end else if (rise_ok) begin
      sh_q   <= byte_in;
      bit_q  <= bit_q + 3'h1;
      seen_q <= 1'b1;
    end
  end

  // output shifter; a fresh byte is taken at each byte boundary
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      so_q   <= 1'b0;
      oe_q   <= 1'b0;
      ob_q   <= 8'h00;
      obit_q <= 3'h0;
      idx_q  <= 1'b0;
    end else if (cs_fall || st_q != S_OUT) begin
      oe_q   <= 1'b0;
      obit_q <= 3'h0;
      idx_q  <= 1'b0;
    end else if (out_fall) begin
      so_q   <= (obit_q == 3'h0) ? next_b[7] : ob_q[7];
      ob_q   <= (obit_q == 3'h0) ? {next_b[6:0], 1'b0} : {ob_q[6:0], 1'b0};
      oe_q   <= 1'b1;
      obit_q <= obit_q + 3'h1;
      idx_q  <= idx_q ^ (obit_q == BIT_LAST);
    end
  end

  // hold releases the pin at once; the shift state stays put
  assign so_pin.so    = so_q;
  assign so_pin.so_oe = oe_q & lv.hold_n & sel;

  // write enable, power down and status bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wen_q  <= 1'b0;
      pd_q   <= 1'b0;
      lock_q <= LOCK_RST;
      bp_q   <= BP_RST;
    end else begin
      if (do_wren) begin
        wen_q <= 1'b1;
      end else if (do_wrdi || do_er || do_pp || do_wrsr) begin
        wen_q <= 1'b0;
      end
      if (do_dpd) begin
        pd_q <= 1'b1;
      end else if (do_res) begin
        pd_q <= 1'b0;
      end
      if (do_wrsr) begin
        lock_q <= sh_q[SR_LOCK];
        bp_q   <= {sh_q[SR_BP1], sh_q[SR_BP0]};
      end
    end
  end

  // busy timer and erase sweep; busy lasts for the longer of the two
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q     <= 32'h0000_0000;
      er_q      <= 1'b0;
      er_addr_q <= '0;
      er_end_q  <= '0;
    end else begin
      if (do_er) begin
        cnt_q     <= (op_q == OP_CE) ? N_CE : (op_q == OP_SE) ? N_SE : N_SSE;
        er_q      <= 1'b1;
        er_addr_q <= er_base;
        er_end_q  <= er_base | er_mask;
      end else if (do_pp) begin
        cnt_q <= N_PP;
      end else begin
        if (cnt_q != 32'h0000_0000) begin
          cnt_q <= cnt_q - 32'h0000_0001;
        end
        if (er_q) begin
          er_addr_q <= er_addr_q + 1'b1;
          er_q      <= (er_addr_q != er_end_q);
        end
      end
    end
  end

  // array: one write port, one registered read port
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[addr_q];
  end

  // checks
  a_so_hiz_in: assert property (@(posedge mclk) disable iff (rst)
    (st_q != S_OUT) |-> !so_pin.so_oe) else $error("output driven outside data phase");
  // the registered enable, not the pin: the pin also returns when hold is let go
  a_so_only_out: assert property (@(posedge mclk) disable iff (rst)
    $rose(oe_q) |-> $past(out_fall)) else $error("output enabled off a fall");
  a_so_on_fall: assert property (@(posedge mclk) disable iff (rst)
    $changed(so_q) |-> $past(out_fall)) else $error("output changed off a fall");
  a_cs_deselect: assert property (@(posedge mclk) disable iff (rst)
    cs_rise |=> (st_q == S_IDLE) && !so_pin.so_oe) else $error("not idle after deselect");
  a_mode_pick: assert property (@(posedge mclk) disable iff (rst)
    cs_fall |=> (mode3_q == $past(lv.sck)) && !seen_q) else $error("wrong mode chosen");
  a_sample_msb: assert property (@(posedge mclk) disable iff (rst)
    rise_ok |=> (sh_q == {$past(sh_q[6:0]), $past(lv.si)})) else $error("bad shift in");
  a_hold_freeze: assert property (@(posedge mclk) disable iff (rst)
    (!lv.hold_n && sel && !cs_fall) |=> $stable(bit_q) && $stable(st_q)) else $error("moved in hold");
  a_wren_sets: assert property (@(posedge mclk) disable iff (rst)
    do_wren |=> wen_q ##1 wen_q) else $error("write enable not set");
  a_short_drop: assert property (@(posedge mclk) disable iff (rst)
    (cs_rise && !cmd_ok_q) |=> $stable(wen_q) && $stable(lock_q) && !$rose(busy)) else $error("short command acted");
  a_lock_holds: assert property (@(posedge mclk) disable iff (rst)
    (cs_rise && locked && op_q == OP_WRSR) |=> $stable(lock_q) && $stable(bp_q)) else $error("locked status written");
  a_pp_busy: assert property (@(posedge mclk) disable iff (rst)
    do_pp |=> busy && (cnt_q == N_PP)) else $error("program busy not started");
  a_erase_ff: assert property (@(posedge mclk) disable iff (rst)
    er_q |-> mem_we && (wdata == ERASED) && busy) else $error("erase sweep not writing");
  a_read_wrap: assert property (@(posedge mclk) disable iff (rst)
    (out_fall && obit_q == BIT_LAST && src_q == SRC_ARRAY && !cs_rise)
    |=> addr_q == AW'($past(addr_q) + 1'b1)) else $error("read address not advanced");
endmodule
`default_nettype wire

// >>> testbench/sfp_host.sv
// host-side serial master model for the flash command port
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
  // core clock, only paces the pins
  input  wire logic               mclk,
  // pins towards the port
  output var  sfp_pkg::sfp_pins_t pins,
  input  wire sfp_pkg::sfp_so_t   so_pin
);
  import sfp_pkg::*;
  int   oe_bad  = 0;    // enable seen while bits go in
  int   oe_seen = 0;    // enable seen while bits come back
  logic hold_oe = 1'b0;

  // idle: deselected, clock still, protect and hold released
  initial pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};

  // pin changes land a fixed skew after the core edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic set_wp(input logic v);
    pins.wp_n = v;
    tick(4);
  endtask

  // one clock period; four core cycles a half keeps pin edges apart
  task automatic bit_cyc(input logic b, input logic din, output logic r);
    pins.sck = 1'b0;
    pins.si  = b;
    tick(4);
    // a released output reads as the inverse of its last level
    r = so_pin.so_oe ? so_pin.so : ~so_pin.so;
    if (so_pin.so_oe && din) oe_bad++;
    if (so_pin.so_oe && !din) oe_seen++;
    pins.sck = 1'b1;
    tick(4);
  endtask

  // one frame: nb bits out msb first, then nr bytes back; mode 3 idles high
  task automatic frame(input logic m3, input logic [7:0] tx[$], input int nb,
                       input int nr, input int hold_at, output logic [7:0] rx[$]);
    logic       r;
    logic [7:0] v;
    rx = {};
    v  = 8'h00;
    pins.sck = m3;
    tick(4);
    pins.cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < nb; i++)
      bit_cyc(tx[i/8][7-i%8], 1'b1, r);
    for (int i = 0; i < nr * 8; i++) begin
      // hold only while the clock is high, so no edge is lost
      if (i == hold_at) begin
        pins.hold_n = 1'b0;
        tick(6);
        hold_oe     = so_pin.so_oe;
        pins.hold_n = 1'b1;
        tick(4);
      end
      bit_cyc(~pins.si, 1'b0, r);
      v = {v[6:0], r};
      if (i % 8 == 7)
        rx.push_back(v);
    end
    pins.sck = m3;
    tick(4);
    pins.cs_n = 1'b1;
    tick(8);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the serial flash command port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfp_pkg::*;
  // identification bytes, values arbitrary; the last two are the port's defaults
  localparam logic [7:0] ID_A = 8'h61;
  localparam logic [7:0] ID_B = 8'hA5;
  localparam logic [7:0] ID_C = 8'h3C;
  logic       mclk       = 1'b0;
  logic       rst        = 1'b1;
  wire sfp_pins_t pins;
  wire sfp_so_t   so_pin;
  int         n_errors   = 0;
  int         n_compared = 0;
  logic [7:0] rx[$];

  // shrunk array and busy counts keep the erase sweeps short
  // sector erase is only ever refused here, so its busy count keeps its default
  sfp_port #(.AW(14), .N_SSE(200), .N_CE(200), .N_PP(200), .ID1_B0(ID_A)) u_sfp_port (
    .mclk(mclk), .rst(rst), .pins(pins), .so_pin(so_pin));
  sfp_host u_sfp_host (.mclk(mclk), .pins(pins), .so_pin(so_pin));

  // 40 MHz core clock
  initial forever #12.5 mclk = ~mclk;

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] q[$]);
    logic [7:0] d[$];
    u_sfp_host.frame(1'b0, q, q.size() * 8, 0, -1, d);
  endtask

  task automatic rd(input logic [7:0] q[$], input int nr);
    u_sfp_host.frame(1'b0, q, q.size() * 8, nr, -1, rx);
  endtask

  task automatic rd_sts(output logic [7:0] s);
    rd({OP_RDSR}, 1);
    s = rx[0];
  endtask

  // poll busy with a cap so a stuck flag cannot hang the run
  task automatic wait_ready();
    logic [7:0] s;
    int         k;
    k = 0;
    rd_sts(s);
    cmp8("busy after start", 8'h01, {7'h00, s[SR_RDY]});
    while (s[SR_RDY] !== 1'b0 && k < 200) begin
      rd_sts(s);
      k++;
    end
    cmp8("busy cleared", 8'h00, {7'h00, s[SR_RDY]});
  endtask

  task automatic prog(input logic [23:0] a, input logic [7:0] d);
    send({OP_WREN});
    send({OP_PP, a[23:16], a[15:8], a[7:0], d});
    wait_ready();
  endtask

  // chip erase is one byte only; an address after it would cancel it
  task automatic erase(input logic [7:0] op, input logic [23:0] a);
    send({OP_WREN});
    if (op == OP_CE)
      send({op});
    else
      send({op, a[23:16], a[15:8], a[7:0]});
    wait_ready();
  endtask

  task automatic t_reset();
    logic [7:0] s;
    cmp8("output enable idle", 8'h00, {7'h00, so_pin.so_oe});
    rd_sts(s);
    cmp8("status after reset", 8'h00, s);
    $display("test reset done");
  endtask

  task automatic t_wen();
    logic [7:0] s;
    send({OP_WREN});
    rd_sts(s);
    cmp8("write enable set", 8'h02, s);
    send({OP_WRDI});
    rd_sts(s);
    cmp8("write enable cleared", 8'h00, s);
    u_sfp_host.frame(1'b0, {OP_WREN}, 5, 0, -1, rx);
    rd_sts(s);
    cmp8("short frame", 8'h00, s);
    u_sfp_host.frame(1'b0, {OP_WREN, 8'h00}, 9, 0, -1, rx);
    rd_sts(s);
    cmp8("extra bit", 8'h00, s);
    $display("test write enable done");
  endtask

  task automatic t_array();
    logic [7:0] s;
    erase(OP_CE, 24'h00_0000);
    send({OP_WREN});
    send({OP_PP, 8'hFC, 8'h0F, 8'hFE, 8'h12, 8'h34, 8'h56});
    wait_ready();
    rd({OP_READ, 8'h00, 8'h0F, 8'hFE}, 2);
    cmp8("read 0ffe", 8'h12, rx[0]);
    cmp8("read 0fff", 8'h34, rx[1]);
    rd({OP_FREAD, 8'h00, 8'h0F, 8'h00, 8'hA5}, 2);
    cmp8("page wrap", 8'h56, rx[0]);
    cmp8("chip erased", 8'hFF, rx[1]);
    prog(24'h00_1000, 8'h77);
    erase(OP_SSE2, 24'h00_1234);
    rd({OP_READ, 8'h00, 8'h0F, 8'hFF}, 2);
    cmp8("below small sector", 8'h34, rx[0]);
    cmp8("small sector erased", 8'hFF, rx[1]);
    erase(OP_SSE, 24'h00_0ABC);
    rd({OP_READ, 8'h00, 8'h0F, 8'hFE}, 1);
    cmp8("small sector erased", 8'hFF, rx[0]);
    prog(24'h00_0F00, 8'h3D);
    send({OP_SE, 8'h00, 8'h00, 8'h00});
    rd_sts(s);
    cmp8("erase without enable", 8'h00, s & 8'h03);
    rd({OP_READ, 8'h00, 8'h0F, 8'h00}, 1);
    cmp8("data kept", 8'h3D, rx[0]);
    $display("test array done");
  endtask

  task automatic t_wrap();
    prog(24'h00_3FFF, 8'hA1);
    prog(24'h00_0000, 8'hB2);
    u_sfp_host.frame(1'b1, {OP_READ, 8'hFF, 8'hFF, 8'hFF}, 32, 2, -1, rx);
    cmp8("top byte mode 3", 8'hA1, rx[0]);
    cmp8("wrap to zero", 8'hB2, rx[1]);
    $display("test wrap done");
  endtask

  task automatic t_status();
    logic [7:0] s;
    send({OP_WREN});
    send({OP_WRSR, 8'h8C});
    send({OP_WRDI});
    u_sfp_host.frame(1'b0, {OP_RDSR}, 8, 2, 11, rx);
    cmp8("status write", 8'h8C, rx[0]);
    cmp8("status repeat", 8'h8C, rx[1]);
    cmp8("hold releases output", 8'h00, {7'h00, u_sfp_host.hold_oe});
    u_sfp_host.set_wp(1'b0);
    send({OP_WREN});
    send({OP_WRSR, 8'h00});
    rd_sts(s);
    cmp8("locked", 8'h8C, s & 8'hFD);
    u_sfp_host.set_wp(1'b1);
    send({OP_WREN});
    send({OP_WRSR, 8'h00, 8'h8C});
    rd_sts(s);
    cmp8("second data byte", 8'h8C, s & 8'hFD);
    send({OP_WRSR, 8'h00});
    rd_sts(s);
    cmp8("unlocked", 8'h00, s & 8'hFD);
    $display("test status done");
  endtask

  task automatic t_id();
    logic [7:0] s;
    int         n;
    rd({OP_RDID}, 2);
    cmp8("id first", ID_A, rx[0]);
    cmp8("id second", ID_B, rx[1]);
    rd({OP_RES, 8'h00, 8'h00, 8'h00}, 1);
    cmp8("id two", ID_C, rx[0]);
    send({OP_DPD});
    send({OP_WREN});
    n = u_sfp_host.oe_seen;
    rd_sts(s);
    cmp8("asleep", 8'h00, 8'(u_sfp_host.oe_seen - n));
    send({OP_RES});
    rd_sts(s);
    cmp8("awake", 8'h00, s);
    cmp8("quiet on input", 8'h00, 8'(u_sfp_host.oe_bad));
    $display("test id done");
  endtask

  // main sequence, reset released a fixed skew after an edge
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    t_reset();
    t_wen();
    t_array();
    t_wrap();
    t_status();
    t_id();
    test_done();
  end

  // hang guard, about two and a half times the expected run
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
